/* design/pem_pkg.sv */
// Package of constants and types for the processor error monitor.
package pem_pkg;
  // Core clock and the timebases derived from it.
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned DELAY_TICK_NS = 2_048_000;
  localparam int unsigned TICK_CYCLES = DELAY_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned DEGLITCH_NS = 15_000;
  localparam int unsigned DEGL_CYCLES = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWM_UNIT_NS = 15_000;
  localparam int unsigned PWM_UNIT_CYCLES = PWM_UNIT_NS / CLK_PERIOD_NS;

  // Register byte offsets on the APB bus.
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CFG = 12'h004;
  localparam logic [11:0] ADDR_PWM = 12'h008;
  localparam logic [11:0] ADDR_IRQ = 12'h00C;
  localparam logic [11:0] ADDR_STAT = 12'h010;

  // Control register fields.
  localparam int CTRL_START = 0;
  localparam int CTRL_DRV = 1;
  localparam int CTRL_EN = 2;
  // Configuration register fields.
  localparam int CFG_D1_LSB = 0;
  localparam int CFG_D2_LSB = 8;
  localparam int CFG_MODE = 16;
  localparam int CFG_ENDRV = 17;
  localparam int CFG_TH_LSB = 20;
  // Pulse threshold register fields.
  localparam int PWM_HMAX_LSB = 0;
  localparam int PWM_HMIN_LSB = 8;
  localparam int PWM_LMAX_LSB = 16;
  localparam int PWM_LMIN_LSB = 24;
  // Interrupt register fields: flags in the low bits, masks above.
  localparam int IRQ_PIN = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_RST = 2;
  localparam int IRQ_MASK_LSB = 8;
  // Status register fields.
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_ST_LSB = 8;
  localparam int STAT_IN = 12;

  // Reset values.
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] PWM_RST = 32'h0000_0000;
  localparam logic [2:0] MASK_RST = 3'h0;

  // Error handling states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    PEM_IDLE = 3'h0,
    PEM_MON = 3'h1,
    PEM_D1 = 3'h3,
    PEM_D2 = 3'h2,
    PEM_TRIG = 3'h6
  } pem_state_t;

  // APB request signals from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pem_apb_req_t;
endpackage : pem_pkg

/* design/pem_top.sv */
// Processor error monitor: deglitch, level and PWM checks, delay stages and APB registers.
`timescale 1ns/100ps
`default_nettype none

module pem_top #(
  parameter int unsigned TICK_CYCLES = pem_pkg::TICK_CYCLES,
  parameter int unsigned DEGL_CYCLES = pem_pkg::DEGL_CYCLES,
  parameter int unsigned UNIT_CYCLES = pem_pkg::PWM_UNIT_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire pem_pkg::pem_apb_req_t apb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic processor_fault_in_n,
  input wire logic monitor_enable_cfg_in,
  input wire logic reset_done_in,
  output logic output_driver_enable_out,
  output logic processor_reset_trigger_out,
  output logic irq_out_n
);
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int DW = $clog2(DEGL_CYCLES + 1);
  localparam int UW = $clog2(UNIT_CYCLES);

  // Counts below these bounds would make the dividers meaningless.
  if (TICK_CYCLES < 2 || DEGL_CYCLES < 1 || UNIT_CYCLES < 2) begin : g_param_check
    $error("pem_top: timing parameters too small");
  end

  pem_pkg::pem_state_t state;
  pem_pkg::pem_state_t next_state;
  logic monitor_enable_cfg;
  logic en_caught;
  logic monitor_start_bit;
  logic output_driver_enable;
  logic [31:0] cfg;
  logic [31:0] pwm;
  logic [2:0] flags;
  logic [2:0] masks;
  logic [31:0] rdata;
  logic [31:0] rd_mux;
  logic [DW-1:0] degl_cnt;
  logic degl;
  logic [UW-1:0] ucnt;
  logic [8:0] len;
  logic prev_lvl;
  logic first;
  logic prev_ok;
  logic [4:0] fault_event_counter;
  logic [TW-1:0] tcnt;
  logic [7:0] dcnt;
  logic set_pin;
  logic set_fail;
  logic set_rst;
  logic drv_clr;
  logic clr_start;
  logic trig;
  logic trig_q;

  // APB decode; the slave never inserts wait states.
  wire access = apb_in.psel && apb_in.penable;
  wire wr = access && apb_in.pwrite;
  wire hit_ctrl = apb_in.paddr == pem_pkg::ADDR_CTRL;
  wire hit_cfg = apb_in.paddr == pem_pkg::ADDR_CFG;
  wire hit_pwm = apb_in.paddr == pem_pkg::ADDR_PWM;
  wire hit_irq = apb_in.paddr == pem_pkg::ADDR_IRQ;
  wire hit_stat = apb_in.paddr == pem_pkg::ADDR_STAT;
  wire hit_any = hit_ctrl || hit_cfg || hit_pwm || hit_irq || hit_stat;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_cfg = wr && hit_cfg;
  wire wr_pwm = wr && hit_pwm;
  wire wr_irq = wr && hit_irq;
  assign pready_out = 1'b1;
  assign pslverr_out = access && !hit_any;
  assign prdata_out = rdata;

  // Configuration fields in use.
  wire [7:0] first_delay_field = cfg[pem_pkg::CFG_D1_LSB +: 8];
  wire [7:0] second_delay_field = cfg[pem_pkg::CFG_D2_LSB +: 8];
  wire monitor_mode_select = cfg[pem_pkg::CFG_MODE];
  wire driver_disable_option = cfg[pem_pkg::CFG_ENDRV];
  wire [3:0] fault_counter_threshold = cfg[pem_pkg::CFG_TH_LSB +: 4];
  wire [7:0] hmax = pwm[pem_pkg::PWM_HMAX_LSB +: 8];
  wire [7:0] hmin = pwm[pem_pkg::PWM_HMIN_LSB +: 8];
  wire [7:0] lmax = pwm[pem_pkg::PWM_LMAX_LSB +: 8];
  wire [7:0] lmin = pwm[pem_pkg::PWM_LMIN_LSB +: 8];
  wire running = monitor_start_bit && monitor_enable_cfg;
  wire pwm_run = running && monitor_mode_select;

  // Read data is sampled in the setup phase and held through the access phase.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[pem_pkg::CTRL_START] = monitor_start_bit;
      rd_mux[pem_pkg::CTRL_DRV] = output_driver_enable;
      rd_mux[pem_pkg::CTRL_EN] = monitor_enable_cfg;
    end
    if (hit_cfg) begin
      rd_mux = cfg;
    end
    if (hit_pwm) begin
      rd_mux = pwm;
    end
    if (hit_irq) begin
      rd_mux[pem_pkg::IRQ_PIN +: 3] = flags;
      rd_mux[pem_pkg::IRQ_MASK_LSB +: 3] = masks;
    end
    if (hit_stat) begin
      rd_mux[pem_pkg::STAT_CNT_LSB +: 5] = fault_event_counter;
      rd_mux[pem_pkg::STAT_ST_LSB +: 3] = state;
      rd_mux[pem_pkg::STAT_IN] = degl;
    end
  end

  // Read data register.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata <= 32'h0000_0000;
    end else if (apb_in.psel && !apb_in.penable) begin
      rdata <= rd_mux;
    end
  end

  // The enable setting is caught once, at the first edge after reset.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      en_caught <= 1'b0;
      monitor_enable_cfg <= 1'b0;
    end else if (!en_caught) begin
      en_caught <= 1'b1;
      monitor_enable_cfg <= monitor_enable_cfg_in;
    end
  end

  // Start bit: software sets it, the final outcome clears it.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      monitor_start_bit <= 1'b0;
    end else if (clr_start) begin
      monitor_start_bit <= 1'b0;
    end else if (wr_ctrl) begin
      monitor_start_bit <= apb_in.pwdata[pem_pkg::CTRL_START] && monitor_enable_cfg;
    end
  end

  // Driver enable: software writes are gated, a late error clears it.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      output_driver_enable <= 1'b0;
    end else if (drv_clr) begin
      output_driver_enable <= 1'b0;
    end else if (wr_ctrl && (monitor_start_bit || !monitor_enable_cfg)) begin
      output_driver_enable <= apb_in.pwdata[pem_pkg::CTRL_DRV];
    end
  end
  assign output_driver_enable_out = output_driver_enable;

  // Configuration is locked while the monitor is started.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg <= pem_pkg::CFG_RST;
      pwm <= pem_pkg::PWM_RST;
    end else if (!monitor_start_bit) begin
      if (wr_cfg) begin
        cfg <= apb_in.pwdata;
      end
      if (wr_pwm) begin
        pwm <= apb_in.pwdata;
      end
    end
  end

  // Flags are write-one-to-clear; a hardware set in the same cycle wins.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flags <= 3'h0;
      masks <= pem_pkg::MASK_RST;
    end else begin
      flags <= (flags & ~(wr_irq ? apb_in.pwdata[pem_pkg::IRQ_PIN +: 3] : 3'h0))
        | {set_rst, set_fail, set_pin};
      if (wr_irq) begin
        masks <= apb_in.pwdata[pem_pkg::IRQ_MASK_LSB +: 3];
      end
    end
  end
  assign irq_out_n = ~|(flags & ~masks);

  // Deglitch filter: the input must hold a new level for the full time.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      degl_cnt <= '0;
      degl <= 1'b1;
    end else if (processor_fault_in_n == degl) begin
      degl_cnt <= '0;
    end else if (degl_cnt == DW'(DEGL_CYCLES - 1)) begin
      degl_cnt <= '0;
      degl <= processor_fault_in_n;
    end else begin
      degl_cnt <= degl_cnt + 1'b1;
    end
  end

  // PWM pulse checks; the pulse in progress has the level held in prev_lvl.
  wire edge_seen = degl != prev_lvl;
  wire [8:0] lim_max = {1'b0, prev_lvl ? hmax : lmax} + 9'h001;
  wire [8:0] lim_min = {1'b0, prev_lvl ? hmin : lmin} + 9'h001;
  wire unit_tick = ucnt == UW'(UNIT_CYCLES - 1);
  wire too_long = len > lim_max;
  wire in_rng = !first && len >= lim_min;
  wire bad = pwm_run && (too_long || (edge_seen && !first && len < lim_min));
  wire good = pwm_run && edge_seen && in_rng && prev_ok;

  // Pulse length counter in units, restarted at each edge or overlong pulse.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ucnt <= '0;
      len <= 9'h000;
      prev_lvl <= 1'b1;
      first <= 1'b1;
      prev_ok <= 1'b0;
    end else if (!pwm_run) begin
      ucnt <= '0;
      len <= 9'h000;
      prev_lvl <= degl;
      first <= 1'b1;
      prev_ok <= 1'b0;
    end else if (edge_seen) begin
      ucnt <= '0;
      len <= 9'h000;
      prev_lvl <= degl;
      first <= 1'b0;
      prev_ok <= in_rng && !prev_ok;
    end else if (too_long) begin
      ucnt <= '0;
      len <= 9'h000;
      first <= 1'b0;
      prev_ok <= 1'b0;
    end else if (unit_tick) begin
      ucnt <= '0;
      len <= len + 9'h001;
    end else begin
      ucnt <= ucnt + 1'b1;
    end
  end

  // Error counter, cleared while stopped, saturating at both ends.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fault_event_counter <= 5'h00;
    end else if (!running) begin
      fault_event_counter <= 5'h00;
    end else if (bad) begin
      fault_event_counter <= (fault_event_counter > 5'h1D) ? 5'h1F : fault_event_counter + 5'h02;
    end else if (good && fault_event_counter != 5'h00) begin
      fault_event_counter <= fault_event_counter - 5'h01;
    end
  end

  // Error condition for either mode.
  wire err = monitor_mode_select ? (fault_event_counter > {1'b0, fault_counter_threshold})
    : !degl;

  // Delay timers: a 2.048 ms tick, restarted on entering each delay stage, advances a count held against the field.
  wire in_delay = state == pem_pkg::PEM_D1 || state == pem_pkg::PEM_D2;
  wire tmr_run = in_delay && next_state == state;
  wire tick = tcnt == TW'(TICK_CYCLES - 1);
  wire expired = dcnt == (state == pem_pkg::PEM_D2 ? second_delay_field : first_delay_field);

  // Timer counters.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tcnt <= '0;
      dcnt <= 8'h00;
    end else if (!tmr_run) begin
      tcnt <= '0;
      dcnt <= 8'h00;
    end else if (tick) begin
      tcnt <= '0;
      dcnt <= dcnt + 8'h01;
    end else begin
      tcnt <= tcnt + 1'b1;
    end
  end

  // Error handling sequence.
  always_comb begin
    next_state = state;
    set_pin = 1'b0;
    set_fail = 1'b0;
    set_rst = 1'b0;
    drv_clr = 1'b0;
    clr_start = 1'b0;
    trig = 1'b0;
    case (state)
      pem_pkg::PEM_IDLE: begin
        if (running) begin
          next_state = pem_pkg::PEM_MON;
        end
      end
      pem_pkg::PEM_MON: begin
        if (!running) begin
          next_state = pem_pkg::PEM_IDLE;
        end else if (err) begin
          set_pin = !masks[pem_pkg::IRQ_PIN];
          next_state = pem_pkg::PEM_D1;
        end
      end
      pem_pkg::PEM_D1: begin
        if (!running) begin
          next_state = pem_pkg::PEM_IDLE;
        end else if (!err && !flags[pem_pkg::IRQ_PIN]) begin
          next_state = pem_pkg::PEM_MON;
        end else if (expired) begin
          drv_clr = driver_disable_option;
          if (second_delay_field == 8'h00) begin
            clr_start = 1'b1;
            set_rst = 1'b1;
            trig = 1'b1;
            next_state = pem_pkg::PEM_TRIG;
          end else begin
            set_fail = !masks[pem_pkg::IRQ_FAIL];
            next_state = pem_pkg::PEM_D2;
          end
        end
      end
      pem_pkg::PEM_D2: begin
        if (!running) begin
          next_state = pem_pkg::PEM_IDLE;
        end else if (!err && !flags[pem_pkg::IRQ_PIN] && !flags[pem_pkg::IRQ_FAIL]) begin
          next_state = pem_pkg::PEM_MON;
        end else if (expired) begin
          clr_start = 1'b1;
          set_rst = 1'b1;
          trig = 1'b1;
          next_state = pem_pkg::PEM_TRIG;
        end
      end
      pem_pkg::PEM_TRIG: begin
        if (reset_done_in) begin
          next_state = pem_pkg::PEM_IDLE;
        end
      end
      default: begin
        next_state = pem_pkg::PEM_IDLE;
      end
    endcase
  end

  // State and reset trigger pulse registers.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= pem_pkg::PEM_IDLE;
      trig_q <= 1'b0;
    end else begin
      state <= next_state;
      trig_q <= trig;
    end
  end
  assign processor_reset_trigger_out = trig_q;

  // Checks on the monitor's own behaviour.
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_d1_exp;
    state == pem_pkg::PEM_D1 && running && err && expired;
  endsequence

  sequence s_d2_exp;
    state == pem_pkg::PEM_D2 && running && (err || flags[pem_pkg::IRQ_PIN]) && expired;
  endsequence

  property p_start_gate;
    !monitor_enable_cfg && en_caught |-> !monitor_start_bit && state != pem_pkg::PEM_MON;
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("monitor runs while disabled");

  property p_stop;
    !monitor_start_bit && state != pem_pkg::PEM_TRIG |=> state == pem_pkg::PEM_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("monitor did not stop");

  property p_drv_guard;
    wr_ctrl && !monitor_start_bit && monitor_enable_cfg |=> $stable(output_driver_enable);
  endproperty
  a_drv_guard: assert property (p_drv_guard) else $error("driver enable write not refused");

  property p_cfg_lock;
    (wr_cfg || wr_pwm) && monitor_start_bit |=> $stable(cfg) && $stable(pwm);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("locked configuration changed");

  property p_cnt_up;
    running && bad && fault_event_counter < 5'h1E |=> fault_event_counter == $past(fault_event_counter) + 5'h02;
  endproperty
  a_cnt_up: assert property (p_cnt_up) else $error("counter did not add two");

  property p_mon_err;
    state == pem_pkg::PEM_MON && pwm_run && fault_event_counter > {1'b0, fault_counter_threshold}
      |=> state == pem_pkg::PEM_D1;
  endproperty
  a_mon_err: assert property (p_mon_err) else $error("counter error not taken");

  property p_pin_irq;
    state == pem_pkg::PEM_MON && running && err && !masks[pem_pkg::IRQ_PIN]
      |=> flags[pem_pkg::IRQ_PIN] && !irq_out_n && dcnt == 8'h00;
  endproperty
  a_pin_irq: assert property (p_pin_irq) else $error("pin flag or interrupt missing");

  property p_recover1;
    state == pem_pkg::PEM_D1 && running && !err && !flags[pem_pkg::IRQ_PIN] |=> state == pem_pkg::PEM_MON;
  endproperty
  a_recover1: assert property (p_recover1) else $error("no recovery in first delay");

  property p_recover2;
    state == pem_pkg::PEM_D2 && running && !err && flags[pem_pkg::IRQ_PIN +: 2] == 2'h0
      |=> state == pem_pkg::PEM_MON;
  endproperty
  a_recover2: assert property (p_recover2) else $error("no recovery in second delay");

  property p_d1_drv;
    s_d1_exp ##0 driver_disable_option |=> !output_driver_enable;
  endproperty
  a_d1_drv: assert property (p_d1_drv) else $error("driver enable not cleared");

  property p_outcome;
    s_d2_exp |=> !monitor_start_bit && processor_reset_trigger_out && flags[pem_pkg::IRQ_RST]
      ##1 !processor_reset_trigger_out;
  endproperty
  a_outcome: assert property (p_outcome) else $error("final outcome wrong");

endmodule : pem_top

`default_nettype wire

/* dv/pem_proc_model.sv */
// Behavioural model of the processor driving its error output line.
`timescale 1ns/100ps
`default_nettype none
module pem_proc_model (
  input wire logic clk_in,
  input wire logic [1:0] mode_in,
  input wire logic [7:0] half_in,
  output logic fault_n_out = 1'b1
);
  // The line starts high, as a healthy processor holds it.
  logic [7:0] cnt = 8'h00;
  logic wrap;

  assign wrap = (cnt + 8'h01) >= half_in;

  // Mode 0 holds the line high, 1 holds it low, 2 toggles every half_in cycles.
  always @(posedge clk_in) begin
    cnt <= wrap ? 8'h00 : cnt + 8'h01;
    if (mode_in == 2'h0) fault_n_out <= 1'b1;
    else if (mode_in == 2'h1) fault_n_out <= 1'b0;
    else if (wrap) fault_n_out <= ~fault_n_out;
  end
endmodule : pem_proc_model
`default_nettype wire

/* dv/testbench.sv */
// Self-checking testbench for the processor error monitor.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  pem_pkg::pem_apb_req_t apb = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, fault_n, drv, trig, irq_n;
  logic en_cfg = 1'b1;
  logic rdone = 1'b0;
  logic [1:0] pmode = 2'h0;
  logic [7:0] phalf = 8'h04;
  logic [4:0] cnt1;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  // Free-running core clock.
  initial begin
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  // Short tick, deglitch and pulse unit keep the run brief.
  pem_top #(.TICK_CYCLES(8), .DEGL_CYCLES(2), .UNIT_CYCLES(4)) pem_top_i (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .apb_in(apb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .processor_fault_in_n(fault_n),
    .monitor_enable_cfg_in(en_cfg), .reset_done_in(rdone), .output_driver_enable_out(drv),
    .processor_reset_trigger_out(trig), .irq_out_n(irq_n));

  pem_proc_model pem_proc_model_i (.clk_in(core_clk_in), .mode_in(pmode), .half_in(phalf),
    .fault_n_out(fault_n));

  // Cuts a hung run short.
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      test_done();
    end
  end

  task automatic test_done();
    $display("counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_pin(input logic got, input logic exp, input string what);
    chk_val({31'h0, got}, {31'h0, exp}, what);
  endtask : chk_pin

  // One APB transfer: setup, then access held until pready is seen high.
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge core_clk_in);
    apb.penable <= 1'b1;
    @(posedge core_clk_in);
    while (pready !== 1'b1) @(posedge core_clk_in);
    rd = prdata;
    err = pslverr;
    apb <= '0;
  endtask : apb_xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb_xfer(1'b0, a, 32'h0);
    chk_val(rd, exp, what);
  endtask : rd_chk

  task automatic wait_irq(input logic lvl);
    n = 0;
    while (irq_n !== lvl && n < 2000) begin
      @(negedge core_clk_in);
      n++;
    end
    chk_pin(irq_n, lvl, "irq level");
  endtask : wait_irq

  // Holds the fault until the reset trigger and checks the outcome and its timing.
  task automatic escalate(input logic [31:0] cfg, input logic [31:0] mask, input logic [31:0] flags,
    input logic drv_exp);
    int lo;
    lo = 8 * (cfg[7:0] + cfg[15:8]) + 2;
    wr(pem_pkg::ADDR_CTRL, 32'h0);
    wr(pem_pkg::ADDR_IRQ, mask | 32'h7);
    wr(pem_pkg::ADDR_CFG, cfg);
    wr(pem_pkg::ADDR_CTRL, 32'h1);
    wr(pem_pkg::ADDR_CTRL, 32'h3);
    pmode <= 2'h1;
    n = 0;
    while (trig !== 1'b1 && n < 600) begin
      @(negedge core_clk_in);
      n++;
    end
    chk_pin(n >= lo && n <= lo + 8, 1'b1, "trigger delay");
    chk_pin(irq_n, mask[10], "irq after trigger");
    chk_pin(drv, drv_exp, "driver enable");
    rd_chk(pem_pkg::ADDR_IRQ, flags | mask, "flags");
    rd_chk(pem_pkg::ADDR_CTRL, {30'h1, drv_exp, 1'b0}, "start cleared");
    rdone <= 1'b1;
    pmode <= 2'h0;
    apb_xfer(1'b0, pem_pkg::ADDR_STAT, 32'h0);
    chk_val({29'h0, rd[10:8]}, 32'h0, "idle after trigger");
    rdone <= 1'b0;
  endtask : escalate

  // Main sequence of tests.
  initial begin
    repeat (16) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    rd_chk(pem_pkg::ADDR_CTRL, 32'h4, "ctrl reset");
    rd_chk(pem_pkg::ADDR_CFG, pem_pkg::CFG_RST, "cfg reset");
    rd_chk(pem_pkg::ADDR_PWM, pem_pkg::PWM_RST, "pwm reset");
    rd_chk(pem_pkg::ADDR_IRQ, 32'h0, "irq reset");
    rd_chk(pem_pkg::ADDR_STAT, 32'h1000, "status reset");
    rd_chk(12'h014, 32'h0, "unmapped read");
    chk_pin(err, 1'b1, "unmapped error");
    $display("test reset values ended");

    wr(pem_pkg::ADDR_CFG, 32'h0000_0008);
    wr(pem_pkg::ADDR_CTRL, 32'h1);
    wr(pem_pkg::ADDR_CTRL, 32'h3);
    @(negedge core_clk_in);
    chk_pin(drv, 1'b1, "driver set while started");
    wr(pem_pkg::ADDR_CFG, 32'h00FF_FFFF);
    rd_chk(pem_pkg::ADDR_CFG, 32'h0000_0008, "cfg locked");
    wr(pem_pkg::ADDR_PWM, 32'hFFFF_FFFF);
    rd_chk(pem_pkg::ADDR_PWM, 32'h0, "pwm locked");
    pmode <= 2'h1;
    wait_irq(1'b0);
    rd_chk(pem_pkg::ADDR_IRQ, 32'h1, "pin flag");
    apb_xfer(1'b0, pem_pkg::ADDR_STAT, 32'h0);
    chk_val({29'h0, rd[10:8]}, 32'h3, "first delay");
    pmode <= 2'h0;
    wr(pem_pkg::ADDR_IRQ, 32'h1);
    wait_irq(1'b1);
    apb_xfer(1'b0, pem_pkg::ADDR_STAT, 32'h0);
    chk_val({29'h0, rd[10:8]}, 32'h1, "monitoring again");
    wr(pem_pkg::ADDR_CTRL, 32'h2);
    wr(pem_pkg::ADDR_CTRL, 32'h0);
    @(negedge core_clk_in);
    chk_pin(drv, 1'b1, "driver write ignored");
    rd_chk(pem_pkg::ADDR_STAT, 32'h1000, "stopped");
    wr(pem_pkg::ADDR_IRQ, 32'h7);
    wr(pem_pkg::ADDR_CFG, 32'h0000_C801);
    wr(pem_pkg::ADDR_CTRL, 32'h1);
    pmode <= 2'h1;
    repeat (30) @(posedge core_clk_in);
    rd_chk(pem_pkg::ADDR_IRQ, 32'h3, "fail flag");
    pmode <= 2'h0;
    wr(pem_pkg::ADDR_IRQ, 32'h3);
    repeat (2) @(posedge core_clk_in);
    rd_chk(pem_pkg::ADDR_STAT, 32'h1100, "second delay recovery");
    $display("test level recovery ended");

    escalate(32'h0002_0202, 32'h0, 32'h7, 1'b0);
    escalate(32'h0000_0001, 32'h0, 32'h5, 1'b1);
    escalate(32'h0002_0101, 32'h700, 32'h4, 1'b0);
    $display("test escalation ended");

    wr(pem_pkg::ADDR_CTRL, 32'h0);
    wr(pem_pkg::ADDR_IRQ, 32'h7);
    wr(pem_pkg::ADDR_CFG, 32'h0031_00C8);
    wr(pem_pkg::ADDR_PWM, 32'h0204_0204);
    pmode <= 2'h2;
    wr(pem_pkg::ADDR_CTRL, 32'h1);
    wait_irq(1'b0);
    apb_xfer(1'b0, pem_pkg::ADDR_STAT, 32'h0);
    cnt1 = rd[4:0];
    chk_pin(cnt1 > 5'h03, 1'b1, "count above threshold");
    phalf <= 8'h10;
    repeat (300) @(posedge core_clk_in);
    apb_xfer(1'b0, pem_pkg::ADDR_STAT, 32'h0);
    chk_pin(rd[4:0] < cnt1, 1'b1, "count falls");
    wr(pem_pkg::ADDR_CTRL, 32'h0);
    apb_xfer(1'b0, pem_pkg::ADDR_STAT, 32'h0);
    chk_val({27'h0, rd[4:0]}, 32'h0, "count cleared");
    pmode <= 2'h0;
    $display("test pwm ended");

    resetn_in <= 1'b0;
    en_cfg <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    wr(pem_pkg::ADDR_CTRL, 32'h3);
    rd_chk(pem_pkg::ADDR_CTRL, 32'h2, "disabled monitor");
    $display("test disabled ended");
    test_done();
  end
endmodule : testbench
`default_nettype wire
